/* File: verilog/serial_link_tx_config_regs.sv */
`timescale 1ns/1ps
`include "lane_tx_defines.svh"
module serial_link_tx_config_regs #(
   parameter int OCTETS_PER_FRAME = 2
) (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       sync_req_n,
   input  wire logic [7:0] sample_octet,
   output logic      [7:0] lane_octet,
   output logic            lane_is_ctrl,
   output logic            link_up,
   output logic      [2:0] output_swing_sel,
   output logic      [2:0] deemphasis_sel
);

   // Refuse frame widths the multiframe counter is not sized for
   if (OCTETS_PER_FRAME < 1 || OCTETS_PER_FRAME > 4) begin : g_bad_frame
      $error("OCTETS_PER_FRAME must be 1 to 4");
   end

   logic [2:0]              swing_ff;
   logic [2:0]              deemph_ff;
   logic                    scramble_on;
   logic [4:0]              frames_per_multiframe_minus_one;
   logic                    link_enable;
   logic [7:0]              rdata_ff;
   lane_tx_pkg::lane_state_e state_ff;
   lane_tx_pkg::lane_state_e nxt_state;
   logic [7:0]              octet_cnt_ff;
   logic [1:0]              mf_cnt_ff;
   logic [14:0]             scr_ff;
   logic [7:0]              octet_ff;
   logic                    ctrl_ff;
   logic                    up_ff;

   // Scramble one octet MSB first; the state holds the last 15 output bits
   function automatic logic [22:0] scramble(input logic [7:0] d, input logic [14:0] s);
      logic [7:0]  o;
      logic [14:0] st;
      o  = 8'h00;
      st = s;
      for (int i = 7; i >= 0; i--) begin
         o[i] = d[i] ^ st[13] ^ st[14];
         st   = {st[13:0], o[i]};
      end
      return {o, st};
   endfunction : scramble

   // Address decode
   wire hit_analog = (reg_addr == `ANALOG_CFG_OFFSET);
   wire hit_ctrl   = (reg_addr == `LINK_CTRL_OFFSET);

   // Reserved bits are not stored and read back as zero
   wire [7:0] analog_view = {1'b0, swing_ff, 1'b0, deemph_ff};
   wire [7:0] ctrl_view   = {scramble_on, frames_per_multiframe_minus_one, 1'b0, link_enable};
   wire [7:0] rd_mux      = hit_analog ? analog_view : (hit_ctrl ? ctrl_view : 8'h00);

   // Register writes and registered read data
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         swing_ff                        <= `SWING_RESET;
         deemph_ff                       <= `DEEMPH_RESET;
         scramble_on                     <= `SCRAMBLE_RESET;
         frames_per_multiframe_minus_one <= `KM1_RESET;
         link_enable                     <= `ENABLE_RESET;
         rdata_ff                        <= 8'h00;
      end else if (ce) begin
         if (reg_wr && hit_analog) begin
            swing_ff  <= reg_wdata[`SWING_MSB:`SWING_LSB];
            deemph_ff <= reg_wdata[`DEEMPH_MSB:`DEEMPH_LSB];
         end
         if (reg_wr && hit_ctrl) begin
            scramble_on                     <= reg_wdata[`SCRAMBLE_BIT];
            frames_per_multiframe_minus_one <= reg_wdata[`KM1_MSB:`KM1_LSB];
            link_enable                     <= reg_wdata[`ENABLE_BIT];
         end
         if (reg_rd)
            rdata_ff <= rd_mux;
      end
   end

   assign reg_rdata        = rdata_ff;
   assign output_swing_sel = swing_ff;
   assign deemphasis_sel   = deemph_ff;

   // Index of the last octet in a multiframe; out-of-range frame counts are not guarded
   wire [7:0] mf_last  = 8'(({3'h0, frames_per_multiframe_minus_one} + 8'h01)
                            * OCTETS_PER_FRAME - 1);
   wire       mf_end   = (octet_cnt_ff == mf_last);
   wire       ilas_end = mf_end && (mf_cnt_ff == `ILAS_MULTIFRAMES);

   // Sequencer: idle pattern, code group sync, alignment sequence, data
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         lane_tx_pkg::ST_IDLE: nxt_state = lane_tx_pkg::ST_CGS;
         lane_tx_pkg::ST_CGS:  if (sync_req_n) nxt_state = lane_tx_pkg::ST_ILAS;
         lane_tx_pkg::ST_ILAS: if (ilas_end) nxt_state = lane_tx_pkg::ST_DATA;
         lane_tx_pkg::ST_DATA: nxt_state = lane_tx_pkg::ST_DATA;
         default:              nxt_state = lane_tx_pkg::ST_IDLE;
      endcase
      // A new sync request restarts synchronization
      if (!sync_req_n && state_ff != lane_tx_pkg::ST_IDLE)
         nxt_state = lane_tx_pkg::ST_CGS;
      if (!link_enable)
         nxt_state = lane_tx_pkg::ST_IDLE;
   end

   // Alignment sequence character for the current position
   wire [7:0] ilas_char = (octet_cnt_ff == 8'h00) ? `CHAR_MF_START :
                          mf_end ? `CHAR_MF_END :
                          (mf_cnt_ff == 2'h1 && octet_cnt_ff == 8'h01) ? `CHAR_CFG_MARK :
                          octet_cnt_ff;
   wire       ilas_ctrl = (octet_cnt_ff == 8'h00) || mf_end ||
                          (mf_cnt_ff == 2'h1 && octet_cnt_ff == 8'h01);
   wire [22:0] scr_res  = scramble(sample_octet, scr_ff);
   wire [7:0]  payload  = scramble_on ? scr_res[22:15] : sample_octet;

   // Lane octet, counters and scrambler state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff     <= lane_tx_pkg::ST_IDLE;
         octet_cnt_ff <= 8'h00;
         mf_cnt_ff    <= 2'h0;
         scr_ff       <= `SCRAMBLE_SEED;
         octet_ff     <= `IDLE_PATTERN;
         ctrl_ff      <= 1'b0;
         up_ff        <= 1'b0;
      end else if (ce) begin
         state_ff     <= nxt_state;
         octet_cnt_ff <= (state_ff != nxt_state || mf_end) ? 8'h00 : octet_cnt_ff + 8'h01;
         if (state_ff != lane_tx_pkg::ST_ILAS)
            mf_cnt_ff <= 2'h0;
         else if (mf_end)
            mf_cnt_ff <= mf_cnt_ff + 2'h1;
         up_ff <= 1'b0;
         case (state_ff)
            lane_tx_pkg::ST_CGS: begin
               octet_ff <= `CHAR_COMMA;
               ctrl_ff  <= 1'b1;
            end
            lane_tx_pkg::ST_ILAS: begin
               octet_ff <= ilas_char;
               ctrl_ff  <= ilas_ctrl;
            end
            lane_tx_pkg::ST_DATA: begin
               // only payload octets pass the scrambler
               octet_ff <= payload;
               ctrl_ff  <= 1'b0;
               if (scramble_on)
                  scr_ff <= scr_res[14:0];
               // up only while data flows
               // A lost sync or a disable drops the flag with the last payload
               up_ff    <= (nxt_state == lane_tx_pkg::ST_DATA);
            end
            default: begin
               octet_ff <= `IDLE_PATTERN;
               ctrl_ff  <= 1'b0;
            end
         endcase
      end
   end

   assign lane_octet   = octet_ff;
   assign lane_is_ctrl = ctrl_ff;
   assign link_up      = up_ff;

   // Checks on register fields and the lane sequence
   a_swing_write_stores: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce && reg_wr && hit_analog |=> output_swing_sel == $past(reg_wdata[6:4]))
      else $error("Swing code not stored");

   a_deemph_write_stores: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce && reg_wr && hit_analog |=> deemphasis_sel == $past(reg_wdata[2:0]))
      else $error("De-emphasis code not stored");

   a_scramble_bit_write: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce && reg_wr && hit_ctrl |=> scramble_on == $past(reg_wdata[7]))
      else $error("Scrambler enable not stored");

   a_frame_count_write: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce && reg_wr && hit_ctrl |=> frames_per_multiframe_minus_one == $past(reg_wdata[6:2]))
      else $error("Frame count not stored");

   a_idle_pattern_out: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce && !link_enable ##1 ce |=> lane_octet == `IDLE_PATTERN && !lane_is_ctrl)
      else $error("Idle pattern missing while disabled");

   a_link_up_data: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(state_ff == lane_tx_pkg::ST_DATA) |-> $past(state_ff) == lane_tx_pkg::ST_ILAS)
      else $error("Data entered without alignment sequence");

   a_link_up_cause: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(link_up) |-> $past(state_ff) == lane_tx_pkg::ST_DATA && $past(sync_req_n))
      else $error("Link up without data state");

   a_clear_payload: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce && state_ff == lane_tx_pkg::ST_DATA && !scramble_on
      |=> lane_octet == $past(sample_octet) && !lane_is_ctrl)
      else $error("Payload not passed through");

   a_scrambled_payload: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce && state_ff == lane_tx_pkg::ST_DATA && scramble_on
      |=> lane_octet == ($past(sample_octet) ^ {$past(scr_ff[13:6]) ^ $past(scr_ff[14:7])})
          && !lane_is_ctrl)
      else $error("Scrambled payload wrong");

endmodule : serial_link_tx_config_regs

/* File: verilog/lane_tx_defines.svh */
`ifndef LANE_TX_DEFINES_SVH
`define LANE_TX_DEFINES_SVH

// Register offsets on the configuration port
`define ANALOG_CFG_OFFSET   8'h47
`define LINK_CTRL_OFFSET    8'h60

// Reset values
`define ANALOG_CFG_RESET    8'h00
`define LINK_CTRL_RESET     8'h7d

// Field positions, lane_tx_analog_config
`define SWING_MSB           6
`define SWING_LSB           4
`define DEEMPH_MSB          2
`define DEEMPH_LSB          0

// Field positions, link_control
`define SCRAMBLE_BIT        7
`define KM1_MSB             6
`define KM1_LSB             2
`define ENABLE_BIT          0

// Field reset values
`define SWING_RESET         3'h0
`define DEEMPH_RESET        3'h0
`define SCRAMBLE_RESET      1'b0
`define KM1_RESET           5'h1f
`define ENABLE_RESET        1'b1

// Lane characters, last alignment multiframe index and scrambler seed
`define IDLE_PATTERN        8'h55
`define CHAR_COMMA          8'hbc
`define CHAR_MF_START       8'h1c
`define CHAR_MF_END         8'h7c
`define CHAR_CFG_MARK       8'h9c
`define CHAR_FRAME_END      8'hfc
`define ILAS_MULTIFRAMES    2'h3
`define SCRAMBLE_SEED       15'h7fff

`endif

/* File: verilog/lane_tx_pkg.sv */
package lane_tx_pkg;

   // Lane transmitter sequence
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CGS  = 2'b01,
      ST_ILAS = 2'b10,
      ST_DATA = 2'b11
   } lane_state_e;

endpackage : lane_tx_pkg

/* File: tb/lane_rx_model.sv */
`timescale 1ns/1ps
// Receiver end of the lane: asks for sync until four commas arrive in a row
module lane_rx_model (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       resync,
   input  wire logic [7:0] lane_octet,
   input  wire logic       lane_is_ctrl,
   output logic            sync_req_n
);
   int commas;

   // Level request; a resync restarts comma alignment from scratch
   always @(negedge ref_clk or negedge rst_n) begin
      if (!rst_n || resync) begin
         commas     = 0;
         sync_req_n = 1'b0;
      end else begin
         if (lane_is_ctrl === 1'b1 && lane_octet === 8'hbc) commas = commas + 1;
         else if (sync_req_n === 1'b0) commas = 0;
         if (commas >= 4) sync_req_n = 1'b1;
      end
   end
endmodule : lane_rx_model

/* File: tb/serial_link_tx_config_regs_tb.sv */
`timescale 1ns/1ps
`include "lane_tx_defines.svh"
module serial_link_tx_config_regs_tb;
   logic       ref_clk      = 1'b0;
   logic       rst_n        = 1'b0;
   logic       ce           = 1'b1;
   logic [7:0] reg_addr     = 8'h00;
   logic [7:0] reg_wdata    = 8'h00;
   logic       reg_wr       = 1'b0;
   logic       reg_rd       = 1'b0;
   logic       resync       = 1'b0;
   logic [7:0] sample_octet = 8'ha5;
   logic [7:0] reg_rdata;
   logic       sync_req_n;
   logic [7:0] lane_octet;
   logic       lane_is_ctrl;
   logic       link_up;
   logic [2:0] output_swing_sel;
   logic [2:0] deemphasis_sel;
   logic [7:0] hold;
   int         err_count    = 0;
   int         n_compared   = 0;
   int         ends;
   int         octs;
   int         diffs;

   always #20 ref_clk = ~ref_clk;

   serial_link_tx_config_regs #(.OCTETS_PER_FRAME(2)) serial_link_tx_config_regs_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sync_req_n(sync_req_n), .sample_octet(sample_octet), .lane_octet(lane_octet),
      .lane_is_ctrl(lane_is_ctrl), .link_up(link_up),
      .output_swing_sel(output_swing_sel), .deemphasis_sel(deemphasis_sel));

   lane_rx_model lane_rx_model_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .resync(resync), .lane_octet(lane_octet),
      .lane_is_ctrl(lane_is_ctrl), .sync_req_n(sync_req_n));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Extra cycle at the end lets registered field outputs settle
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(negedge ref_clk);
      reg_addr  = addr;
      reg_wdata = data;
      reg_wr    = 1'b1;
      @(negedge ref_clk);
      reg_wr    = 1'b0;
      @(negedge ref_clk);
   endtask : wr

   task automatic rdchk(input string what, input logic [7:0] addr, input logic [7:0] exp);
      @(negedge ref_clk);
      reg_addr = addr;
      reg_rd   = 1'b1;
      @(negedge ref_clk);
      reg_rd   = 1'b0;
      check(what, reg_rdata, exp);
   endtask : rdchk

   // Counts multiframe ends and alignment octets until the link reports up
   task automatic wait_link();
      ends = 0;
      octs = 0;
      for (int i = 0; i < 400 && link_up !== 1'b1; i++) begin
         @(negedge ref_clk);
         if (lane_is_ctrl === 1'b1 && lane_octet === `CHAR_MF_END) ends++;
         if ((octs > 0 || (lane_is_ctrl === 1'b1 && lane_octet === `CHAR_MF_START))
             && link_up !== 1'b1) octs++;
      end
      check("link up", {7'h00, link_up}, 8'h01);
   endtask : wait_link

   task automatic print_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   // Watchdog far beyond the few hundred cycles the sequence needs
   initial begin
      #400us;
      err_count++;
      print_verdict();
   end

   initial begin
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b1;
      // Defaults and an unmapped place
      rdchk("analog reset", `ANALOG_CFG_OFFSET, 8'h00);
      rdchk("control reset", `LINK_CTRL_OFFSET, 8'h7d);
      rdchk("unmapped", 8'h10, 8'h00);
      // All eight codes of both selectors, reserved bits kept at zero
      for (int i = 0; i < 8; i++) begin
         wr(`ANALOG_CFG_OFFSET, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
         check("swing", {5'h00, output_swing_sel}, 8'(i));
         check("deemph", {5'h00, deemphasis_sel}, 8'(7 - i));
         rdchk("analog rb", `ANALOG_CFG_OFFSET, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
      end
      // Disabled lane; receiver keeps requesting so the relink is honest
      resync = 1'b1;
      wr(`LINK_CTRL_OFFSET, 8'h7c);
      repeat (2) @(negedge ref_clk);
      for (int i = 0; i < 4; i++) begin
         check("idle octet", lane_octet, `IDLE_PATTERN);
         check("idle ctrl", {7'h00, lane_is_ctrl}, 8'h00);
         @(negedge ref_clk);
      end
      check("link down", {7'h00, link_up}, 8'h00);
      // Nine frames of two octets, changed only while disabled
      wr(`LINK_CTRL_OFFSET, 8'h20);
      wr(`LINK_CTRL_OFFSET, 8'h21);
      resync = 1'b0;
      wait_link();
      check("ilas ends", 8'(ends), 8'h04);
      check("ilas octets", 8'(octs), 8'd72);
      check("payload", lane_octet, 8'ha5);
      check("payload ctrl", {7'h00, lane_is_ctrl}, 8'h00);
      rdchk("control rb", `LINK_CTRL_OFFSET, 8'h21);
      // Scrambler on: control characters plain, payload changed
      resync = 1'b1;
      wr(`LINK_CTRL_OFFSET, 8'h20);
      wr(`LINK_CTRL_OFFSET, 8'ha0);
      wr(`LINK_CTRL_OFFSET, 8'ha1);
      resync = 1'b0;
      wait_link();
      check("scr ilas ends", 8'(ends), 8'h04);
      diffs = 0;
      repeat (8) begin
         @(negedge ref_clk);
         if (lane_octet !== 8'ha5) diffs++;
      end
      check("scrambled", 8'(diffs > 0), 8'h01);
      // Clock enable low freezes the lane
      ce   = 1'b0;
      hold = lane_octet;
      repeat (3) @(negedge ref_clk);
      check("frozen", lane_octet, hold);
      ce   = 1'b1;
      // A sync request drops the link back to commas
      resync = 1'b1;
      repeat (4) @(negedge ref_clk);
      check("resync octet", lane_octet, `CHAR_COMMA);
      check("resync link", {7'h00, link_up}, 8'h00);
      resync = 1'b0;
      print_verdict();
   end
endmodule : serial_link_tx_config_regs_tb
